// file: rtl/hbe_host_port.sv
// host bus port: 16-bit asynchronous strobes to a 32-bit internal little endian bus
// assumes strobes arrive from pins and internal reads answer with rd_ack_i later
`timescale 1ns/100ps
`include "hbe_cfg.svh"
module hbe_host_port
  import hbe_pkg::*;
#(
  parameter int ADDR_W = `HBE_DW_ADDR_W,
  parameter int TXLVL_CYC = `HBE_TXLVL_CYC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // internal reset condition still active (same clock domain)
  input wire logic int_reset_i,
  // host pins
  input wire logic chip_select_strobe_low_i,
  input wire logic read_strobe_low_i,
  input wire logic write_strobe_low_i,
  input wire logic word_half_address_line_i,
  input wire logic [ADDR_W-1:0] dw_addr_i,
  input wire logic endian_select_i,
  input wire logic fifo_select_i,
  input wire logic [15:0] host_data_i,
  output logic [15:0] host_data_o,
  output logic host_data_oe_b_o,
  // internal write request
  output logic wr_valid_o,
  output hbe_int_req_s wr_req_o,
  // internal read request and answer
  output logic rd_valid_o,
  output hbe_int_req_s rd_req_o,
  input wire logic rd_ack_i,
  input wire logic [31:0] rd_data_i,
  // transmit fifo level update strobe, settles the info register
  output logic tx_level_upd_o
);
  // pin synchronisers: three stages, a change counts when stages two and three agree
  localparam int SYNC_W = 4 + ADDR_W + 2 + 16;
  logic [SYNC_W-1:0] s1_q, s2_q, s3_q, s1_d, s2_d, s3_d;
  logic [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] stab_q, stab_d;
  assign pins = {chip_select_strobe_low_i, read_strobe_low_i, write_strobe_low_i,
    word_half_address_line_i, dw_addr_i, endian_select_i, fifo_select_i, host_data_i};
  // synchroniser next values
  always_comb begin
    s1_d = pins;
    s2_d = s1_q;
    s3_d = s2_q;
    stab_d = stab_q;
    for (int i = 0; i < SYNC_W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        stab_d[i] = s3_q[i];
      end
    end
  end

  // synchroniser flops; strobes idle high at reset
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_q <= {3'h7, {(SYNC_W-3){1'b0}}};
      s2_q <= {3'h7, {(SYNC_W-3){1'b0}}};
      s3_q <= {3'h7, {(SYNC_W-3){1'b0}}};
      stab_q <= {3'h7, {(SYNC_W-3){1'b0}}};
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      stab_q <= stab_d;
    end
  end

  // unpacked view of the stable pins
  logic cs_b, rd_b, wr_b, half, big_end, fifo_sel;
  logic [ADDR_W-1:0] addr;
  logic [15:0] hdata;
  assign {cs_b, rd_b, wr_b, half, addr, big_end, fifo_sel, hdata} = stab_q;

  // a cycle is active while both chip select and its strobe are low, so either
  // strobe may be the one that frames the timing
  logic rd_act, wr_act;
  assign rd_act = !cs_b && !rd_b;
  assign wr_act = !cs_b && !wr_b;

  // cycle tracking
  hbe_cyc_e cyc_q, cyc_d;
  logic rd_start, rd_end, wr_end;
  always_comb begin
    cyc_d = cyc_q;
    rd_start = 1'b0;
    rd_end = 1'b0;
    wr_end = 1'b0;
    case (cyc_q)
      HBE_IDLE: begin
        if (rd_act) begin
          cyc_d = HBE_READ;
          rd_start = 1'b1;
        end else if (wr_act) begin
          cyc_d = HBE_WRITE;
        end
      end
      HBE_READ: begin
        if (!rd_act) begin
          cyc_d = HBE_IDLE;
          rd_end = 1'b1;
        end
      end
      HBE_WRITE: begin
        // data latched at the trailing edge of the write strobe
        if (!wr_act) begin
          cyc_d = HBE_IDLE;
          wr_end = 1'b1;
        end
      end
      default: cyc_d = HBE_IDLE;
    endcase
  end

  // reset falling away mid-read: the rest of that read is ignored
  logic int_reset_q, reset_end, skip_rd_q, skip_rd_d;
  assign reset_end = int_reset_q && !int_reset_i;

  // write lock after reset, released by the first completed read
  logic wr_lock_q, wr_lock_d;
  // pairing state
  logic pend_q, pend_d;
  logic pend_half_q, pend_half_d;
  logic pend_rd_q, pend_rd_d;
  logic [15:0] lo_q, lo_d, hi_q, hi_d;
  logic [31:0] rbuf_q, rbuf_d;
  hbe_int_req_s wr_req_q, wr_req_d, rd_req_q, rd_req_d;
  logic wr_valid_q, wr_valid_d, rd_valid_q, rd_valid_d, rd_wait_q, rd_wait_d;
  logic [15:0] host_q, host_d;
  logic [15:0] sw_host, sw_int;
  logic [7:0] txcnt_q, txcnt_d;
  logic upd_q, upd_d;

  // lane steering, endian select taken fresh on each access
  hbe_lane_swap u_swap (
    .big_end_i(big_end),
    .half_i(half),
    .word_i(rd_ack_i ? rd_data_i : rbuf_q),
    .host_i(hdata),
    .host_o(sw_host),
    .int_half_o(sw_int)
  );

  // access control next values
  always_comb begin
    skip_rd_d = skip_rd_q;
    wr_lock_d = wr_lock_q;
    pend_d = pend_q;
    pend_half_d = pend_half_q;
    pend_rd_d = pend_rd_q;
    lo_d = lo_q;
    hi_d = hi_q;
    rbuf_d = rbuf_q;
    wr_req_d = wr_req_q;
    rd_req_d = rd_req_q;
    wr_valid_d = 1'b0;
    rd_valid_d = 1'b0;
    rd_wait_d = rd_wait_q;
    host_d = host_q;
    txcnt_d = txcnt_q;
    upd_d = 1'b0;
    if (txcnt_q != 8'h00) begin // count down first; a fifo write below reloads it
      txcnt_d = txcnt_q - 8'h01;
      upd_d = (txcnt_q == 8'h01);
    end
    if (int_reset_i) begin
      // any reset locks writes again
      wr_lock_d = `HBE_WRITE_LOCK_RST;
    end
    if (reset_end) begin
      // a half pair begun in reset is dropped; the next read starts fresh
      pend_d = 1'b0;
      if (cyc_q == HBE_READ) begin
        skip_rd_d = 1'b1;
      end
    end
    if (rd_start) begin
      if (pend_q && pend_rd_q && pend_half_q != half && rd_req_q.addr == addr) begin
        // second half served from the held word
        host_d = sw_host;
        pend_d = 1'b0;
      end else begin
        // first half (or same half again): fetch a whole word, restart the pair
        rd_req_d.addr = addr;
        rd_req_d.fifo = fifo_sel;
        rd_req_d.data = 32'h0000_0000;
        rd_valid_d = 1'b1;
        rd_wait_d = 1'b1;
        pend_d = 1'b1;
        pend_rd_d = 1'b1;
        pend_half_d = half;
      end
    end
    if (rd_wait_q && rd_ack_i) begin
      rbuf_d = rd_data_i;
      host_d = sw_host;
      rd_wait_d = 1'b0;
    end
    if (rd_end) begin
      if (skip_rd_q) begin
        skip_rd_d = 1'b0;
      end else if (!int_reset_i) begin
        wr_lock_d = 1'b0;
      end
    end
    if (wr_end && !wr_lock_q && !int_reset_i) begin
      if (pend_q && !pend_rd_q && pend_half_q != half && wr_req_q.addr == addr
          && wr_req_q.fifo == fifo_sel) begin
        // opposite half of the same word completes one internal write
        wr_req_d.data = half ? {sw_int, lo_q} : {hi_q, sw_int};
        wr_valid_d = 1'b1;
        pend_d = 1'b0;
        if (fifo_sel) begin
          txcnt_d = TXLVL_CYC[7:0];
        end
      end else if (!(pend_q && !pend_rd_q && pend_half_q == half)) begin
        // first half of a pair; a repeated half is disregarded, data and all
        if (half) begin
          hi_d = sw_int;
        end else begin
          lo_d = sw_int;
        end
        wr_req_d.addr = addr;
        wr_req_d.fifo = fifo_sel;
        pend_d = 1'b1;
        pend_rd_d = 1'b0;
        pend_half_d = half;
      end
    end
  end

  // access control flops
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cyc_q <= HBE_IDLE;
      int_reset_q <= 1'b0;
      skip_rd_q <= 1'b0;
      wr_lock_q <= 1'b1;
      pend_q <= 1'b0;
      pend_half_q <= 1'b0;
      pend_rd_q <= 1'b0;
      lo_q <= `HBE_HALF_LO;
      hi_q <= `HBE_HALF_LO;
      rbuf_q <= 32'h0000_0000;
      wr_req_q <= '0;
      rd_req_q <= '0;
      wr_valid_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_wait_q <= 1'b0;
      host_q <= 16'h0000;
      txcnt_q <= 8'h00;
      upd_q <= 1'b0;
    end else begin
      cyc_q <= cyc_d;
      int_reset_q <= int_reset_i;
      skip_rd_q <= skip_rd_d;
      wr_lock_q <= wr_lock_d;
      pend_q <= pend_d;
      pend_half_q <= pend_half_d;
      pend_rd_q <= pend_rd_d;
      lo_q <= lo_d;
      hi_q <= hi_d;
      rbuf_q <= rbuf_d;
      wr_req_q <= wr_req_d;
      rd_req_q <= rd_req_d;
      wr_valid_q <= wr_valid_d;
      rd_valid_q <= rd_valid_d;
      rd_wait_q <= rd_wait_d;
      host_q <= host_d;
      txcnt_q <= txcnt_d;
      upd_q <= upd_d;
    end
  end

  // outputs; data bus driven only during a read cycle
  assign host_data_o = host_q;
  assign host_data_oe_b_o = !(cyc_q == HBE_READ);
  assign wr_valid_o = wr_valid_q;
  assign wr_req_o = wr_req_q;
  assign rd_valid_o = rd_valid_q;
  assign rd_req_o = rd_req_q;
  assign tx_level_upd_o = upd_q;

  // no write reaches the inside while locked
  lock_blocks_wr_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $rose(wr_valid_q) |-> $past(!wr_lock_q))
    else $error("internal write issued while writes locked");

  // a fifo write leads to the level strobe within one to six cycles
  sequence fifo_wr_s;
    wr_valid_q && wr_req_q.fifo;
  endsequence
  tx_level_time_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    fifo_wr_s |-> ##[1:6] upd_q)
    else $error("transmit level strobe late");

  // reset asserted re-locks writes on the next edge
  reset_relock_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    int_reset_i |=> wr_lock_q)
    else $error("reset did not lock writes");

  // a reset end with no read start or write end in that cycle drops any half pair
  pair_drop_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (reset_end && !rd_start && !wr_end) |=> !pend_q)
    else $error("half pair kept across reset end");

  // a read that straddles reset end does not unlock writes
  tail_ignored_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (reset_end && cyc_q == HBE_READ) |=> skip_rd_q)
    else $error("read tail not ignored");

  // fifo select forces the fifo target on requests
  fifo_route_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (rd_start && fifo_sel && !pend_q) |=> rd_req_q.fifo && rd_valid_q)
    else $error("fifo read not routed to fifo");

  // read answer lands with the selected byte order
  rd_lane_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (rd_wait_q && rd_ack_i && !big_end && !half) |=> host_q == rbuf_q[15:0])
    else $error("little endian low half wrong");

  // a whole word leaves only after a pair
  pair_write_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_valid_q |-> $past(pend_q && !pend_rd_q))
    else $error("write issued without a pending half");
endmodule

// file: rtl/hbe_cfg.svh
// constants for the host bus endian port: offsets, field positions, timing counts
// assumes a 40 MHz system clock; included by the package and the host port module
`ifndef HBE_CFG_SVH
`define HBE_CFG_SVH
`define HBE_CLK_PERIOD_NS 25
`define HBE_TXLVL_MAX_NS 135
// longest time rounds down, never under one cycle
`define HBE_TXLVL_CYC ((`HBE_TXLVL_MAX_NS / `HBE_CLK_PERIOD_NS) < 1 ? 1 : \
  (`HBE_TXLVL_MAX_NS / `HBE_CLK_PERIOD_NS))
`define HBE_DW_ADDR_W 8
`define HBE_HALF_LO 16'h0000
`define HBE_WRITE_LOCK_RST 1'b1
`define HBE_HALF_BIT 0
`endif

// file: rtl/hbe_pkg.sv
// types shared by the host bus endian port
// assumes hbe_cfg.svh is on the include path
`include "hbe_cfg.svh"
package hbe_pkg;
  typedef enum logic [1:0] {
    HBE_IDLE,
    HBE_READ,
    HBE_WRITE
  } hbe_cyc_e;
  // one internal 32-bit little endian access
  typedef struct packed {
    logic [`HBE_DW_ADDR_W-1:0] addr;
    logic fifo;
    logic [31:0] data;
  } hbe_int_req_s;
endpackage

// file: rtl/hbe_lane_swap.sv
// byte lane steering between one 16-bit host half and the 32-bit internal word
// assumes purely combinational use inside the host port
`timescale 1ns/100ps
module hbe_lane_swap
  import hbe_pkg::*;
(
  // control
  input wire logic big_end_i,
  input wire logic half_i,
  // data
  input wire logic [31:0] word_i,
  input wire logic [15:0] host_i,
  output logic [15:0] host_o,
  output logic [15:0] int_half_o
);
  logic [15:0] sel_half;
  always_comb begin
    // little endian: high half goes on word line one, bytes unchanged
    sel_half = half_i ? word_i[31:16] : word_i[15:0];
    if (big_end_i) begin
      // big endian: the more significant byte sits on the low host lane
      host_o = {sel_half[7:0], sel_half[15:8]};
      int_half_o = {host_i[7:0], host_i[15:8]};
    end else begin
      host_o = sel_half;
      int_half_o = host_i;
    end
  end
endmodule

// file: tb/hbe_host_model.sv
// host cpu model: drives 16-bit strobe cycles onto the host pins
// assumes a 25 ns clock; tasks are called from the bench top
`timescale 1ns/100ps
module hbe_host_model
  import hbe_pkg::*;
(
  // clock
  input wire logic clk_sys_i,
  // read answer from the port
  input wire logic [15:0] host_data_o,
  input wire logic host_data_oe_b_o,
  // host pins
  output logic cs_b_o,
  output logic rd_b_o,
  output logic wr_b_o,
  output logic half_o,
  output logic end_o,
  output logic fifo_o,
  output logic [7:0] addr_o,
  output logic [15:0] data_o
);
  // idle bus: strobes high
  initial begin
    cs_b_o = 1'b1;
    rd_b_o = 1'b1;
    wr_b_o = 1'b1;
    half_o = 1'b0;
    end_o = 1'b0;
    fifo_o = 1'b0;
    addr_o = 8'h00;
    data_o = 16'h0000;
  end

  // one half cycle; cs_last picks which strobe times the cycle
  task automatic cyc(input logic wr, input logic h, input logic [7:0] a, input logic e,
                     input logic f, input logic [15:0] d, input logic cs_last,
                     output logic [15:0] q, output logic oe_b);
    @(negedge clk_sys_i);
    half_o = h;
    addr_o = a;
    end_o = e;
    fifo_o = f;
    if (wr) data_o = d;
    if (cs_last) begin
      if (wr) wr_b_o = 1'b0;
      else rd_b_o = 1'b0;
    end else cs_b_o = 1'b0;
    @(negedge clk_sys_i);
    cs_b_o = 1'b0;
    if (wr) wr_b_o = 1'b0;
    else rd_b_o = 1'b0;
    repeat (12) @(negedge clk_sys_i);
    q = host_data_o;
    oe_b = host_data_oe_b_o;
    cs_b_o = 1'b1;
    rd_b_o = 1'b1;
    wr_b_o = 1'b1;
    // data held past the synchroniser, then no stale copy left on the lines
    repeat (5) @(negedge clk_sys_i);
    data_o = ~data_o;
    // 14 idle cycles cover the longest read-after-write wait
    repeat (9) @(negedge clk_sys_i);
  endtask
endmodule

// file: tb/host_bus_endian_and_cycle_rules_tb.sv
// self-checking bench for the host bus endian port
// assumes hbe_host_model stands on the host pins; bench answers internal reads
`timescale 1ns/100ps
module host_bus_endian_and_cycle_rules_tb;
  import hbe_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic int_reset_i = 1'b0;
  logic cs_b, rd_b, wr_b, half, endn, fifo, oe_b, wr_valid, rd_valid, upd;
  logic [7:0] addr;
  logic [15:0] hd_i, hd_o;
  hbe_int_req_s wr_req, rd_req, last_wr;
  logic rd_ack_i = 1'b0;
  logic [31:0] rd_data_i = 32'h00000000;
  logic rd_fifo;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int n_wr = 0;
  int n_upd = 0;
  int n_rd = 0;
  int t_wr = 0;
  int t_upd = 0;

  always #12.5 clk_sys_i = ~clk_sys_i;

  hbe_host_port dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .int_reset_i(int_reset_i),
    .chip_select_strobe_low_i(cs_b), .read_strobe_low_i(rd_b), .write_strobe_low_i(wr_b),
    .word_half_address_line_i(half), .dw_addr_i(addr), .endian_select_i(endn),
    .fifo_select_i(fifo), .host_data_i(hd_i), .host_data_o(hd_o), .host_data_oe_b_o(oe_b),
    .wr_valid_o(wr_valid), .wr_req_o(wr_req), .rd_valid_o(rd_valid), .rd_req_o(rd_req),
    .rd_ack_i(rd_ack_i), .rd_data_i(rd_data_i), .tx_level_upd_o(upd));

  hbe_host_model host (.clk_sys_i(clk_sys_i), .host_data_o(hd_o), .host_data_oe_b_o(oe_b),
    .cs_b_o(cs_b), .rd_b_o(rd_b), .wr_b_o(wr_b), .half_o(half), .end_o(endn),
    .fifo_o(fifo), .addr_o(addr), .data_o(hd_i));

  // internal word held at each doubleword address; all four bytes differ for every address the bench uses
  function automatic logic [31:0] wd(input logic [7:0] a);
    return {a, 8'h5A, ~a, 8'hC3};
  endfunction

  // host lane view of one half of an internal word
  function automatic logic [15:0] hv(input logic [31:0] w, input logic h, input logic e);
    logic [15:0] x;
    x = h ? w[31:16] : w[15:0];
    return e ? {x[7:0], x[15:8]} : x;
  endfunction

  // internal side answers one cycle after each request; idle data toggles so a
  // word taken outside the answer cycle shows up as a mismatch
  always @(negedge clk_sys_i) begin
    if (rd_valid === 1'b1) begin
      rd_ack_i <= 1'b1;
      rd_data_i <= wd(rd_req.addr);
      rd_fifo <= rd_req.fifo;
    end else begin
      rd_ack_i <= 1'b0;
      rd_data_i <= ~rd_data_i;
    end
  end

  // write, read and level pulse monitor at mid-cycle where outputs are settled
  always @(negedge clk_sys_i) begin
    cyc++;
    if (wr_valid === 1'b1) begin
      n_wr++;
      last_wr = wr_req;
      t_wr = cyc;
    end
    if (rd_valid === 1'b1) begin
      n_rd++;
    end
    if (upd === 1'b1) begin
      n_upd++;
      t_upd = cyc;
    end
    // the whole run needs about 510 cycles
    if (cyc == 2000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // read pair starting with half h0, each half compared with the stored word
  task automatic rdp(input logic [7:0] a, input logic e, input logic f, input logic csl,
                     input logic h0);
    logic [15:0] q;
    logic ob;
    host.cyc(1'b0, h0, a, e, f, 16'h0000, csl, q, ob);
    chk("read first half", q, hv(wd(a), h0, e));
    chk("read drive enable", ob, 1'b0);
    host.cyc(1'b0, ~h0, a, e, f, 16'h0000, csl, q, ob);
    chk("read second half", q, hv(wd(a), ~h0, e));
  endtask

  // write pair carrying word wd(a); dup repeats the first half
  task automatic wrp(input logic [7:0] a, input logic e, input logic f, input logic h0,
                     input logic dup);
    logic [15:0] q;
    logic ob;
    host.cyc(1'b1, h0, a, e, f, hv(wd(a), h0, e), 1'b0, q, ob);
    chk("write drive enable", ob, 1'b1);
    if (dup) begin
      // the repeat carries other data, which must not reach the combined word
      host.cyc(1'b1, h0, a, e, f, ~hv(wd(a), h0, e), 1'b1, q, ob);
    end
    host.cyc(1'b1, ~h0, a, e, f, hv(wd(a), ~h0, e), 1'b1, q, ob);
  endtask

  // writes locked by reset; read tail across reset end does not unlock
  task automatic t_lock();
    int n0;
    int r0;
    logic [15:0] q;
    logic ob;
    n0 = n_wr;
    int_reset_i = 1'b1;
    wrp(8'h11, 1'b0, 1'b0, 1'b0, 1'b0);
    chk("write count locked", n_wr, n0);
    fork
      host.cyc(1'b0, 1'b0, 8'h11, 1'b0, 1'b0, 16'h0000, 1'b0, q, ob);
      begin
        repeat (8) @(negedge clk_sys_i);
        int_reset_i = 1'b0;
      end
    join
    wrp(8'h11, 1'b0, 1'b0, 1'b0, 1'b0);
    chk("write count after tail", n_wr, n0);
    // the low half begun in reset is dropped, so the high half fetches afresh
    r0 = n_rd;
    host.cyc(1'b0, 1'b1, 8'h11, 1'b0, 1'b0, 16'h0000, 1'b1, q, ob);
    chk("fresh fetch count", n_rd, r0 + 1);
    chk("read high half", q, hv(wd(8'h11), 1'b1, 1'b0));
    rdp(8'h22, 1'b0, 1'b0, 1'b1, 1'b1);
    wrp(8'h33, 1'b0, 1'b0, 1'b0, 1'b0);
    chk("write count unlocked", n_wr, n0 + 1);
    chk("write word", last_wr.data, wd(8'h33));
    chk("write addr", last_wr.addr, 8'h33);
    chk("write fifo flag", last_wr.fifo, 1'b0);
    $display("test lock done");
  endtask

  // big endian fifo write, high half first, repeated half, level pulse delay
  task automatic t_fifo_wr();
    int n0;
    int u0;
    n0 = n_wr;
    u0 = n_upd;
    wrp(8'h44, 1'b1, 1'b1, 1'b1, 1'b1);
    repeat (12) @(negedge clk_sys_i);
    chk("write count dup", n_wr, n0 + 1);
    chk("write word big", last_wr.data, wd(8'h44));
    chk("write fifo flag", last_wr.fifo, 1'b1);
    chk("level pulses", n_upd, u0 + 1);
    chk("level delay", t_upd - t_wr, 5);
    $display("test fifo write done");
  endtask

  // mixed endian reads, each strobe timing, fifo routing
  task automatic t_rd_mix();
    rdp(8'h55, 1'b1, 1'b0, 1'b1, 1'b0);
    chk("read fifo flag", rd_fifo, 1'b0);
    rdp(8'h66, 1'b0, 1'b1, 1'b0, 1'b1);
    chk("read fifo flag", rd_fifo, 1'b1);
    $display("test read mix done");
  endtask

  task automatic finish_test();
    $display("counts: compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge clk_sys_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    t_lock();
    t_fifo_wr();
    t_rd_mix();
    finish_test();
  end
endmodule
